/* rtl/csw_switch_control.sv */
// Notes on behaviour
// - Four 4:1 selectors; any input may feed one or several outputs.
// - Mode low selects serial programming, mode high selects pin patterns.
// - One commit updates all four output routes together.
// - Commit low, mode low: serial data shifts in on each rising serial clock.
// - Cascade data outputs repeat the input, own address field decremented.
// - Mode low: cascade clocks are buffered copies of serial clock.
// - Commit high at rising serial clock copies staging into configuration.
// - Commit held high repeats the copy on every further rising edge.
// - Mode high: internal logic sees no serial clock edges.
// - Mode high: both cascade clocks stay low.
// - Commit applies routes only from the last valid complete frame.
// - New routing takes effect without further serial clock edges.
// - Select patterns are ignored while mode is low; select-high then carries serial data.
// - Selects 00: input one to all outputs.
// - Selects 01: input two to all outputs.
// - Selects 10: input one to outputs 1-2, input three to 3-4.
// - Selects 11: each input to the output of the same number.
// - Frame is 30 bits, most significant bit first.
// - Six-bit start pattern; one value loads, the other is received but never staged.
// - Start, row address, column address, then four 3-bit routes.
// - Route 0 floats the output, 1..4 pick inputs, 5..7 invalid.
`timescale 1ns/1ns
`include "csw_defines.svh"

module csw_switch_control (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic serialClock,
   input wire logic pinSelectHi,
   input wire logic pinSelectLo,
   input wire logic commitStrobe,
   input wire logic modeSelect,
   input wire logic laneIn1,
   input wire logic laneIn2,
   input wire logic laneIn3,
   input wire logic laneIn4,
   output logic laneOut1,
   output logic laneOut2,
   output logic laneOut3,
   output logic laneOut4,
   output logic laneOut1En_n,
   output logic laneOut2En_n,
   output logic laneOut3En_n,
   output logic laneOut4En_n,
   output logic rowCascadeData,
   output logic columnCascadeData,
   output logic rowCascadeClock,
   output logic columnCascadeClock,
   output logic stagingValid,
   output logic frameRejected
);

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic [5:0] decAddr(input logic [5:0] addr);
      return addr - 6'h01;
   endfunction

   function automatic logic routeOk(input csw_pkg::csw_route_t r);
      return (r.lane1 <= `CSW_SEL_MAX) && (r.lane2 <= `CSW_SEL_MAX) &&
             (r.lane3 <= `CSW_SEL_MAX) && (r.lane4 <= `CSW_SEL_MAX);
   endfunction

   function automatic logic [`CSW_ADDR_BITS-1:0] shiftIn(input logic [`CSW_ADDR_BITS-1:0] lineIn, input logic bitIn);
      return {lineIn[`CSW_ADDR_BITS-2:0], bitIn};
   endfunction

   // Fixed routes of the select-pin mode
   function automatic csw_pkg::csw_route_t pinPattern(input logic hi, input logic lo);
      csw_pkg::csw_route_t r;
      r = `CSW_PAT_BROAD;
      if (!hi && !lo) begin
         r = `CSW_PAT_DIST1;
      end else if (!hi && lo) begin
         r = `CSW_PAT_DIST2;
      end else if (hi && !lo) begin
         r = `CSW_PAT_REDUND;
      end
      return r;
   endfunction

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   csw_pkg::csw_pins_t pinsRaw;
   csw_pkg::csw_pins_t pins;

   assign pinsRaw = '{serialClock: serialClock, selectHi: pinSelectHi,
                      selectLo: pinSelectLo, commit: commitStrobe,
                      mode: modeSelect,
                      lanes: {laneIn4, laneIn3, laneIn2, laneIn1}};

   csw_sync #(.WIDTH($bits(csw_pkg::csw_pins_t))) pinSync (
      .mclk(mclk),
      .reset_n(reset_n),
      .async(pinsRaw),
      .synced(pins)
   );

   // ----------------------------------------
   // Serial clock edge detection
   // ----------------------------------------
   logic sclkLast_q;
   logic serialMode;
   logic sclkRise;
   logic dataBit;

   // Resets to the parked low level, so no false edge follows reset
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         sclkLast_q <= 1'b0;
      end else begin
         sclkLast_q <= pins.serialClock;
      end
   end

   assign serialMode = ~pins.mode;
   // Edges are gated off in pin mode so nothing internal moves
   assign sclkRise = pins.serialClock & ~sclkLast_q & serialMode;
   // Select-high pin doubles as serial data
   assign dataBit = pins.selectHi;

   // ----------------------------------------
   // Frame receiver
   // ----------------------------------------
   csw_pkg::csw_rx_state_t rxState_q;
   logic [`CSW_START_BITS-1:0] window_q;
   logic [`CSW_START_BITS-1:0] windowNext;
   logic isLoad_q;
   logic [4:0] bodyCount_q;
   logic [`CSW_BODY_BITS-2:0] body_q;
   csw_pkg::csw_body_t bodyFull;
   logic frameDone;
   logic frameGood;

   assign windowNext = {window_q[`CSW_START_BITS-2:0], dataBit};
   assign bodyFull = {body_q, dataBit};
   assign frameDone = sclkRise && !pins.commit && rxState_q == csw_pkg::CSW_BODY &&
                      bodyCount_q == `CSW_BODY_LAST_CNT;
   // Only load frames addressed here with legal routes reach staging
   assign frameGood = isLoad_q && bodyFull.row == 6'h00 &&
                      bodyFull.column == 6'h00 && routeOk(bodyFull.route);

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         rxState_q <= csw_pkg::CSW_HUNT;
         window_q <= '0;
         isLoad_q <= 1'b0;
         bodyCount_q <= 5'h00;
         body_q <= '0;
      end else if (sclkRise && !pins.commit) begin
         case (rxState_q)
            csw_pkg::CSW_HUNT: begin
               window_q <= windowNext;
               if (windowNext == `CSW_START_LOAD || windowNext == `CSW_START_READ) begin
                  rxState_q <= csw_pkg::CSW_BODY;
                  isLoad_q <= (windowNext == `CSW_START_LOAD);
                  bodyCount_q <= 5'h00;
               end
            end
            csw_pkg::CSW_BODY: begin
               body_q <= bodyFull[`CSW_BODY_BITS-2:0];
               bodyCount_q <= bodyCount_q + 5'h01;
               if (bodyCount_q == `CSW_BODY_LAST_CNT) begin
                  // Restart the hunt clean so body bits cannot fake a start
                  rxState_q <= csw_pkg::CSW_HUNT;
                  window_q <= '0;
               end
            end
            default: begin
               rxState_q <= csw_pkg::CSW_HUNT;
            end
         endcase
      end
   end

   // ----------------------------------------
   // Staging and configuration registers
   // ----------------------------------------
   csw_pkg::csw_route_t staging_q;
   csw_pkg::csw_route_t config_q;
   logic stagingValid_q;
   logic frameRejected_q;

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         staging_q <= `CSW_ROUTE_RESET;
      end else if (frameDone && frameGood) begin
         staging_q <= bodyFull.route;
      end
   end

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         stagingValid_q <= 1'b0;
      end else if (frameDone && frameGood) begin
         stagingValid_q <= 1'b1;
      end
   end

   // Sticky until a good frame; read-back frames leave it alone
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         frameRejected_q <= 1'b0;
      end else if (frameDone && frameGood) begin
         frameRejected_q <= 1'b0;
      end else if (frameDone && isLoad_q && !routeOk(bodyFull.route)) begin
         frameRejected_q <= 1'b1;
      end
   end

   // Whole route word moves at once, repeated while commit stays high
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         config_q <= `CSW_ROUTE_RESET;
      end else if (sclkRise && pins.commit) begin
         config_q <= staging_q;
      end
   end

   // ----------------------------------------
   // Route selection
   // ----------------------------------------
   csw_pkg::csw_route_t activeRoute;

   always_comb begin
      activeRoute = config_q;
      if (pins.mode) begin
         activeRoute = pinPattern(pins.selectHi, pins.selectLo);
      end
   end

   // ----------------------------------------
   // Crosspoint
   // ----------------------------------------
   logic [3:0] xbarOut;
   logic [3:0] xbarOff;
   logic [3:0] laneOut_q;
   logic [3:0] laneOff_q;

   csw_crossbar xbar (
      .route(activeRoute),
      .lanesIn(pins.lanes),
      .lanesOut(xbarOut),
      .lanesOff(xbarOff)
   );

   // Follows the route every cycle, no serial edge needed
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         laneOut_q <= 4'h0;
         laneOff_q <= 4'hf;
      end else begin
         laneOut_q <= xbarOut & ~xbarOff;
         laneOff_q <= xbarOff;
      end
   end

   // ----------------------------------------
   // Cascade forwarding
   // ----------------------------------------
   // Six-bit delay lets the address be rewritten before it leaves
   logic [`CSW_ADDR_BITS-1:0] rowLine_q;
   logic [`CSW_ADDR_BITS-1:0] colLine_q;
   logic [`CSW_ADDR_BITS-1:0] lineNext;
   logic [`CSW_ADDR_BITS-1:0] colLineNext;
   logic rowData_q;
   logic colData_q;
   logic rowFieldIn;
   logic colFieldIn;

   assign lineNext = shiftIn(rowLine_q, dataBit);
   assign colLineNext = shiftIn(colLine_q, dataBit);
   assign rowFieldIn = rxState_q == csw_pkg::CSW_BODY && bodyCount_q == `CSW_ROW_DONE_CNT;
   assign colFieldIn = rxState_q == csw_pkg::CSW_BODY && bodyCount_q == `CSW_COL_DONE_CNT;

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         rowLine_q <= '0;
         rowData_q <= 1'b0;
      end else if (sclkRise) begin
         rowData_q <= rowLine_q[`CSW_ADDR_BITS-1];
         if (rowFieldIn && !pins.commit) begin
            rowLine_q <= decAddr(lineNext);
         end else begin
            rowLine_q <= lineNext;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         colLine_q <= '0;
         colData_q <= 1'b0;
      end else if (sclkRise) begin
         colData_q <= colLine_q[`CSW_ADDR_BITS-1];
         if (colFieldIn && !pins.commit) begin
            colLine_q <= decAddr(colLineNext);
         end else begin
            colLine_q <= colLineNext;
         end
      end
   end

   logic rowClk_q;
   logic colClk_q;

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         rowClk_q <= 1'b0;
      end else begin
         rowClk_q <= pins.serialClock & serialMode;
      end
   end

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         colClk_q <= 1'b0;
      end else begin
         colClk_q <= pins.serialClock & serialMode;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign laneOut1 = laneOut_q[0];
   assign laneOut2 = laneOut_q[1];
   assign laneOut3 = laneOut_q[2];
   assign laneOut4 = laneOut_q[3];
   assign laneOut1En_n = laneOff_q[0];
   assign laneOut2En_n = laneOff_q[1];
   assign laneOut3En_n = laneOff_q[2];
   assign laneOut4En_n = laneOff_q[3];
   assign rowCascadeData = rowData_q;
   assign columnCascadeData = colData_q;
   assign rowCascadeClock = rowClk_q;
   assign columnCascadeClock = colClk_q;
   assign stagingValid = stagingValid_q;
   assign frameRejected = frameRejected_q;

endmodule

/* rtl/csw_defines.svh */
`ifndef CSW_DEFINES_SVH
`define CSW_DEFINES_SVH

// ----------------------------------------
// Control frame layout
// ----------------------------------------
`define CSW_FRAME_BITS 30
`define CSW_START_BITS 6
`define CSW_BODY_BITS 24
`define CSW_ADDR_BITS 6
`define CSW_ROUTE_BITS 12
`define CSW_START_LOAD 6'h1f
`define CSW_START_READ 6'h1e
`define CSW_ROW_MSB 23
`define CSW_ROW_LSB 18
`define CSW_COL_MSB 17
`define CSW_COL_LSB 12
`define CSW_ROW_DONE_CNT 5'h05
`define CSW_COL_DONE_CNT 5'h0b
`define CSW_BODY_LAST_CNT 5'h17

// ----------------------------------------
// Routing field codes
// ----------------------------------------
`define CSW_SEL_OFF 3'h0
`define CSW_SEL_MAX 3'h4
`define CSW_ROUTE_RESET 12'h000

// ----------------------------------------
// Fixed pin-select patterns
// ----------------------------------------
`define CSW_PAT_DIST1 12'h249
`define CSW_PAT_DIST2 12'h492
`define CSW_PAT_REDUND 12'h25b
`define CSW_PAT_BROAD 12'h29c

// ----------------------------------------
// Timing
// ----------------------------------------
`define CSW_SCLK_MAX_MHZ 100
`define CSW_MCLK_MHZ 125

`endif

/* rtl/csw_pkg.sv */
package csw_pkg;

   typedef logic [2:0] csw_field_t;

   typedef struct packed {
      csw_field_t lane1;
      csw_field_t lane2;
      csw_field_t lane3;
      csw_field_t lane4;
   } csw_route_t;

   typedef struct packed {
      logic [5:0] row;
      logic [5:0] column;
      csw_route_t route;
   } csw_body_t;

   typedef struct packed {
      logic serialClock;
      logic selectHi;
      logic selectLo;
      logic commit;
      logic mode;
      logic [3:0] lanes;
   } csw_pins_t;

   typedef enum logic [0:0] {
      CSW_HUNT = 1'b0,
      CSW_BODY = 1'b1
   } csw_rx_state_t;

endpackage

/* rtl/csw_sync.sv */
`timescale 1ns/1ns

module csw_sync #(
   parameter int WIDTH = 1
) (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic [WIDTH-1:0] async,
   output logic [WIDTH-1:0] synced
);

   logic [WIDTH-1:0] stage1_q;
   logic [WIDTH-1:0] stage2_q;

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         stage1_q <= '0;
         stage2_q <= '0;
      end else begin
         stage1_q <= async;
         stage2_q <= stage1_q;
      end
   end

   assign synced = stage2_q;

endmodule

/* rtl/csw_crossbar.sv */
`timescale 1ns/1ns

module csw_crossbar (
   input wire csw_pkg::csw_route_t route,
   input wire logic [3:0] lanesIn,
   output logic [3:0] lanesOut,
   output logic [3:0] lanesOff
);

   // Field 0 floats the lane; 1..4 pick an input
   function automatic logic pickLane(input csw_pkg::csw_field_t sel, input logic [3:0] lanes);
      logic bit_;
      bit_ = 1'b0;
      if (sel == 3'h1) begin
         bit_ = lanes[0];
      end else if (sel == 3'h2) begin
         bit_ = lanes[1];
      end else if (sel == 3'h3) begin
         bit_ = lanes[2];
      end else if (sel == 3'h4) begin
         bit_ = lanes[3];
      end
      return bit_;
   endfunction

   csw_pkg::csw_field_t sel [4];

   always_comb begin
      sel[0] = route.lane1;
      sel[1] = route.lane2;
      sel[2] = route.lane3;
      sel[3] = route.lane4;
      for (int i = 0; i < 4; i++) begin
         lanesOut[i] = pickLane(sel[i], lanesIn);
         lanesOff[i] = (sel[i] == 3'h0);
      end
   end

endmodule

/* verif/csw_ctrl_model.sv */
`timescale 1ns/1ns
module csw_ctrl_model (
   input wire logic mclk,
   input wire logic rowData,
   input wire logic colData,
   output logic sclk,
   output logic sdata,
   output logic commit
);
   logic [29:0] rowCap = 30'h0;
   logic [29:0] colCap = 30'h0;
   initial begin
      sclk = 1'b0;
      sdata = 1'b0;
      commit = 1'b0;
   end
   // ------
   // Serial access
   // ------
   task automatic pulse();
      repeat (10) @(negedge mclk);
      sclk = 1'b1;
      repeat (10) @(negedge mclk);
      rowCap = {rowCap[28:0], rowData};
      colCap = {colCap[28:0], colData};
      sclk = 1'b0; // Parked low between accesses
   endtask
   task automatic frame(input logic [29:0] f);
      for (int i = 29; i >= 0; i--) begin
         sdata = f[i];
         pulse();
      end
      sdata = 1'b0;
      repeat (6) pulse(); // Flush the six-bit cascade line
      sdata = 1'b1; // Released line shows the inverse
   endtask
   task automatic load(input int n);
      commit = 1'b1;
      repeat (n) pulse();
      commit = 1'b0;
   endtask
endmodule

/* verif/csw_switch_control_chk.sv */
`timescale 1ns/1ns
module csw_switch_control_chk (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic serialClock,
   input wire logic pinSelectHi,
   input wire logic pinSelectLo,
   input wire logic commitStrobe,
   input wire logic modeSelect,
   input wire logic laneIn1,
   input wire logic laneIn2,
   input wire logic laneIn3,
   input wire logic laneIn4,
   input wire logic laneOut1,
   input wire logic laneOut2,
   input wire logic laneOut3,
   input wire logic laneOut4,
   input wire logic laneOut1En_n,
   input wire logic laneOut2En_n,
   input wire logic laneOut3En_n,
   input wire logic laneOut4En_n,
   input wire logic rowCascadeData,
   input wire logic columnCascadeData,
   input wire logic rowCascadeClock,
   input wire logic columnCascadeClock,
   input wire logic stagingValid,
   input wire logic frameRejected
);
   wire logic [1:0] sel = {pinSelectHi, pinSelectLo};
   wire logic [3:0] lo = {laneOut4, laneOut3, laneOut2, laneOut1};
   wire logic [3:0] en = {laneOut4En_n, laneOut3En_n, laneOut2En_n, laneOut1En_n};
   logic [3:0] l1_q, l2_q, l3_q;
   // Lane inputs pass the two-stage sync plus the output register
   always_ff @(posedge mclk) begin
      l1_q <= {laneIn4, laneIn3, laneIn2, laneIn1};
      l2_q <= l1_q;
      l3_q <= l2_q;
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (!reset_n);
   dist_one_a: assert property ((modeSelect && sel == 2'h0)[*6] |->
      lo == {4{l3_q[0]}} && en == 4'h0) else $error("pattern 00 wrong");
   dist_two_a: assert property ((modeSelect && sel == 2'h1)[*6] |->
      lo == {4{l3_q[1]}} && en == 4'h0) else $error("pattern 01 wrong");
   redund_pat_a: assert property ((modeSelect && sel == 2'h2)[*6] |->
      lo == {l3_q[2], l3_q[2], l3_q[0], l3_q[0]} && en == 4'h0) else $error("pattern 10 wrong");
   straight_pat_a: assert property ((modeSelect && sel == 2'h3)[*6] |->
      lo == l3_q && en == 4'h0) else $error("pattern 11 wrong");
   cfg_hold_a: assert property ((!modeSelect && !commitStrobe)[*8] |-> $stable(en))
      else $error("routing moved without commit");
   status_hold_a: assert property (modeSelect[*6] |->
      $stable(stagingValid) && $stable(frameRejected)) else $error("status moved in pin mode");
   casc_clk_low_a: assert property (modeSelect[*5] |->
      !rowCascadeClock && !columnCascadeClock) else $error("cascade clock active in pin mode");
   casc_clk_copy_a: assert property ((!modeSelect)[*6] ##0 $rose(serialClock) |->
      ##3 rowCascadeClock && columnCascadeClock) else $error("cascade clock not following");
   casc_data_edge_a: assert property ($changed({rowCascadeData, columnCascadeData}) |->
      rowCascadeClock && !$past(rowCascadeClock)) else $error("cascade data off edge");
endmodule
bind csw_switch_control csw_switch_control_chk csw_switch_control_chk_inst (.mclk, .reset_n,
   .serialClock, .pinSelectHi, .pinSelectLo, .commitStrobe, .modeSelect, .laneIn1, .laneIn2,
   .laneIn3, .laneIn4, .laneOut1, .laneOut2, .laneOut3, .laneOut4, .laneOut1En_n, .laneOut2En_n,
   .laneOut3En_n, .laneOut4En_n, .rowCascadeData, .columnCascadeData, .rowCascadeClock,
   .columnCascadeClock, .stagingValid, .frameRejected);

/* verif/tb_csw_switch_control.sv */
`timescale 1ns/1ns
module tb_csw_switch_control;
   logic mclk = 1'b0;
   logic reset_n = 1'b0;
   logic modeSelect = 1'b0;
   logic selHi = 1'b0;
   logic pinSelectLo = 1'b0;
   logic [3:0] lin = 4'h5;
   logic [3:0] lo, en;
   wire logic sclk, sdata, commit, rowData, colData, stagingValid, frameRejected;
   int err_total = 0;
   int checks_done = 0;
   int cycles = 0;
   logic [11:0] pat [4] = '{12'h249, 12'h492, 12'h25b, 12'h29c};
   logic [29:0] bad [3] = '{{6'h1f, 6'h01, 6'h00, 12'h492}, {6'h1e, 12'h000, 12'h249},
      {6'h1f, 12'h000, 12'h8c7}};
   logic rej [3] = '{1'b0, 1'b0, 1'b1};
   always #4 mclk = ~mclk;
   csw_ctrl_model csw_ctrl_model_inst (.mclk(mclk), .rowData(rowData), .colData(colData),
      .sclk(sclk), .sdata(sdata), .commit(commit));
   csw_switch_control csw_switch_control_inst (.mclk(mclk), .reset_n(reset_n), .serialClock(sclk),
      .pinSelectHi(modeSelect ? selHi : sdata), .pinSelectLo(pinSelectLo), .commitStrobe(commit),
      .modeSelect(modeSelect), .laneIn1(lin[0]), .laneIn2(lin[1]), .laneIn3(lin[2]), .laneIn4(lin[3]),
      .laneOut1(lo[0]), .laneOut2(lo[1]), .laneOut3(lo[2]), .laneOut4(lo[3]), .laneOut1En_n(en[0]),
      .laneOut2En_n(en[1]), .laneOut3En_n(en[2]), .laneOut4En_n(en[3]), .rowCascadeData(rowData),
      .columnCascadeData(colData), .rowCascadeClock(), .columnCascadeClock(),
      .stagingValid(stagingValid), .frameRejected(frameRejected));
   // ------
   // Checking helpers
   // ------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_total++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   function automatic logic [7:0] expect_lanes(input logic [11:0] r);
      logic [2:0] f;
      expect_lanes = 8'h00;
      for (int k = 0; k < 4; k++) begin
         f = r[11-3*k -: 3];
         expect_lanes[k+4] = (f == 3'h0);
         expect_lanes[k] = (f == 3'h0) ? 1'b0 : lin[f-3'h1];
      end
   endfunction
   // Two lane patterns so a stuck or swapped selector shows
   task automatic lanes(input logic [11:0] r);
      lin = 4'h5;
      repeat (8) @(negedge mclk);
      check({en, lo}, expect_lanes(r));
      lin = 4'ha;
      repeat (8) @(negedge mclk);
      check({en, lo}, expect_lanes(r));
   endtask
   task automatic stop_test();
      $display("checks %0d errors %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 30000) begin
         err_total++;
         stop_test();
      end
   end
   // ------
   // Sequence
   // ------
   initial begin
      repeat (6) @(negedge mclk);
      reset_n = 1'b1;
      check(stagingValid, 1'b0);
      csw_ctrl_model_inst.frame({6'h1f, 12'h000, 12'h8c1});
      check(stagingValid, 1'b1);
      check(en, 4'hf);
      check(csw_ctrl_model_inst.rowCap, {6'h1f, 6'h3f, 6'h00, 12'h8c1});
      check(csw_ctrl_model_inst.colCap, {6'h1f, 6'h00, 6'h3f, 12'h8c1});
      csw_ctrl_model_inst.load(1);
      lanes(12'h8c1);
      for (int i = 0; i < 3; i++) begin
         csw_ctrl_model_inst.frame(bad[i]);
         check(frameRejected, rej[i]);
         csw_ctrl_model_inst.load(1);
         lanes(12'h8c1);
      end
      csw_ctrl_model_inst.frame({6'h1f, 12'h000, 12'h50a});
      check(frameRejected, 1'b0);
      csw_ctrl_model_inst.load(2);
      lanes(12'h50a);
      modeSelect = 1'b1;
      for (int s = 0; s < 4; s++) begin
         {selHi, pinSelectLo} = s[1:0];
         lanes(pat[s]);
      end
      // Clock bursts in pin mode must not reach the receiver
      csw_ctrl_model_inst.frame({6'h1f, 12'h000, 12'h000});
      lanes(pat[3]);
      {selHi, pinSelectLo} = 2'h1;
      modeSelect = 1'b0;
      lanes(12'h50a);
      csw_ctrl_model_inst.load(1);
      lanes(12'h50a);
      stop_test();
   end
endmodule
